// file: core/asw_cfg.svh
// Timing and width constants for the asynchronous SRAM port controller
`ifndef ASW_CFG_SVH
`define ASW_CFG_SVH
`define ASW_CLK_PERIOD_NS 10
`define ASW_ADDR_W 18
`define ASW_DATA_W 16
// Read access time, address/select to data valid
`define ASW_READ_ACCESS_NS 45
// Device may still drive the bus this long after write strobe falls
`define ASW_WRITE_STROBE_TO_FLOAT_NS 18
// Write strobe pulse width
`define ASW_WRITE_PULSE_NS 35
// Output enable high to float
`define ASW_OE_TO_FLOAT_NS 18
// Recovery after supply returns from retention
`define ASW_RECOVERY_NS 45
// Deselect to retention least time
`define ASW_DESELECT_TO_RETENTION_NS 0
// Least-time counts, rounded up, at least one cycle
`define ASW_CYC_UP(ns) (((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS)
`define ASW_READ_CYC (`ASW_CYC_UP(`ASW_READ_ACCESS_NS) + 1)
`define ASW_FLOAT_CYC `ASW_CYC_UP(`ASW_WRITE_STROBE_TO_FLOAT_NS)
`define ASW_WPULSE_CYC `ASW_CYC_UP(`ASW_WRITE_PULSE_NS)
`define ASW_TURN_CYC `ASW_CYC_UP(`ASW_OE_TO_FLOAT_NS)
`define ASW_RECOVER_CYC `ASW_CYC_UP(`ASW_RECOVERY_NS)
`endif

// file: core/asw_pkg.sv
// Types for the asynchronous SRAM port controller
package asw_pkg;
  typedef enum logic [2:0] {
    ASW_IDLE,
    ASW_READ,
    ASW_WRITE_WAIT,
    ASW_WRITE_DRIVE,
    ASW_TURN,
    ASW_RETAIN,
    ASW_RECOVER
  } asw_state_e;
endpackage : asw_pkg

// file: core/asw_host.sv
// Host controller driving an asynchronous 16-bit word/byte SRAM port
`timescale 1ns/1ns
`include "asw_cfg.svh"
// How it works
// - Reads hold write strobe high throughout
// - Write starts with select, strobe, lane together
// - Write ends by strobe; data held past it
// - Drive data only after float wait
// - Lane enables stay high while deselected
// - Address set on the same edge select falls
// - Deselected before retention begins
// - Wait recovery time after retention exit
module asw_host (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [`ASW_ADDR_W-1:0] i_req_addr,
  input wire logic [`ASW_DATA_W-1:0] i_req_wdata,
  input wire logic [1:0] i_req_lanes,
  output logic o_rsp_valid,
  output logic [`ASW_DATA_W-1:0] o_rsp_rdata,
  input wire logic i_retain_req,
  output logic o_retained,
  output logic [`ASW_ADDR_W-1:0] o_sram_addr,
  output logic o_select_first_n,
  output logic o_select_second,
  output logic o_write_en_n,
  output logic o_output_en_n,
  output logic o_upper_lane_en_n,
  output logic o_lower_lane_en_n,
  input wire logic [`ASW_DATA_W-1:0] i_sram_data,
  output logic [`ASW_DATA_W-1:0] o_sram_data,
  output logic o_sram_data_oe_n
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  asw_pkg::asw_state_e state;
  asw_pkg::asw_state_e next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [`ASW_ADDR_W-1:0] next_sram_addr;
  logic [`ASW_DATA_W-1:0] next_sram_data;
  logic [`ASW_DATA_W-1:0] next_rsp_rdata;
  logic [1:0] lanes;
  logic [1:0] next_lanes;
  logic sel;
  logic next_sel;
  logic we;
  logic next_we;
  logic oe;
  logic next_oe;
  logic drive;
  logic next_drive;
  logic rsp;
  logic next_rsp;
  logic [`ASW_DATA_W-1:0] d1;
  logic [`ASW_DATA_W-1:0] d2;
  logic [`ASW_DATA_W-1:0] d3;

  // Cycle count narrowed to the counter; keeps width casts in one place
  function automatic logic [7:0] cyc(input int n);
    cyc = (n < 1) ? 8'h01 : 8'(n);
  endfunction : cyc

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  // select pair
  assign o_select_first_n = ~sel;
  assign o_select_second = sel;
  assign o_write_en_n = ~we;
  assign o_output_en_n = ~oe;
  // lane enables; both high whenever deselected
  assign o_upper_lane_en_n = ~(sel & lanes[1]);
  assign o_lower_lane_en_n = ~(sel & lanes[0]);
  assign o_sram_data_oe_n = ~drive;
  assign o_req_ready = (state == asw_pkg::ASW_IDLE) & ~i_retain_req;
  assign o_rsp_valid = rsp;
  assign o_retained = (state == asw_pkg::ASW_RETAIN);

  // ----------------------------------------
  // Read data capture, three-stage delay pipeline on the async bus
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    d1 <= i_sram_data;
    d2 <= d1;
    d3 <= d2;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Every transfer returns through idle, so lanes never toggle unselected
  always_comb begin
    next_state = state;
    next_count = count;
    next_sram_addr = o_sram_addr;
    next_sram_data = o_sram_data;
    next_rsp_rdata = o_rsp_rdata;
    next_lanes = lanes;
    next_sel = sel;
    next_we = we;
    next_oe = oe;
    next_drive = drive;
    next_rsp = 1'b0;
    case (state)
      asw_pkg::ASW_IDLE: begin
        // idle is deselected with bus released
        next_sel = 1'b0;
        next_we = 1'b0;
        next_oe = 1'b0;
        next_drive = 1'b0;
        // retention only entered from the deselected idle state
        if (i_retain_req) begin
          next_state = asw_pkg::ASW_RETAIN;
        end else if (i_req_valid && i_req_lanes != 2'h0) begin
          // address and lanes latched on the same edge select falls
          next_sram_addr = i_req_addr;
          next_lanes = i_req_lanes;
          next_sram_data = i_req_wdata;
          next_sel = 1'b1;
          if (i_req_write) begin
            // select, strobe, lanes asserted in the same edge
            next_we = 1'b1;
            next_count = cyc(`ASW_FLOAT_CYC);
            next_state = asw_pkg::ASW_WRITE_WAIT;
          end else begin
            // strobe kept high; bus already released
            next_oe = 1'b1;
            next_count = cyc(`ASW_READ_CYC);
            next_state = asw_pkg::ASW_READ;
          end
        end
      end
      asw_pkg::ASW_READ: begin
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          // Sample only after the three-stage delay pipeline has settled
          next_rsp_rdata = d3;
          next_rsp = 1'b1;
          next_sel = 1'b0;
          next_oe = 1'b0;
          // output enable high lets the device float before any drive
          next_count = cyc(`ASW_TURN_CYC);
          next_state = asw_pkg::ASW_TURN;
        end
      end
      asw_pkg::ASW_WRITE_WAIT: begin
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          // drive data only once the device has floated
          next_drive = 1'b1;
          next_count = cyc(`ASW_WPULSE_CYC);
          next_state = asw_pkg::ASW_WRITE_DRIVE;
        end
      end
      asw_pkg::ASW_WRITE_DRIVE: begin
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          // strobe ends the write; data held one cycle after
          // select drops with the strobe, so no read glitch
          next_we = 1'b0;
          next_sel = 1'b0;
          next_rsp = 1'b1;
          next_count = 8'h01;
          next_state = asw_pkg::ASW_TURN;
        end
      end
      asw_pkg::ASW_TURN: begin
        next_drive = 1'b0;
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          next_state = asw_pkg::ASW_IDLE;
        end
      end
      asw_pkg::ASW_RETAIN: begin
        if (!i_retain_req) begin
          next_count = cyc(`ASW_RECOVER_CYC);
          next_state = asw_pkg::ASW_RECOVER;
        end
      end
      asw_pkg::ASW_RECOVER: begin
        // hold off accesses for the recovery time
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          next_state = asw_pkg::ASW_IDLE;
        end
      end
      default: begin
        next_state = asw_pkg::ASW_IDLE;
      end
    endcase
  end

  // State, counter, 18-bit word address, data, per-lane mask and pin control registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= asw_pkg::ASW_IDLE;
      count <= 8'h00;
      o_sram_addr <= '0;
      o_sram_data <= '0;
      o_rsp_rdata <= '0;
      lanes <= 2'h0;
      sel <= 1'b0;
      we <= 1'b0;
      oe <= 1'b0;
      drive <= 1'b0;
      rsp <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      o_sram_addr <= next_sram_addr;
      o_sram_data <= next_sram_data;
      o_rsp_rdata <= next_rsp_rdata;
      lanes <= next_lanes;
      sel <= next_sel;
      we <= next_we;
      oe <= next_oe;
      drive <= next_drive;
      rsp <= next_rsp;
    end
  end

endmodule : asw_host

// file: bench/asw_mem_model.sv
// Behavioural 16-bit asynchronous SRAM at the host pins
`timescale 1ns/1ns
module asw_mem_model (
  input wire logic i_clk,
  input wire logic [17:0] i_a,
  input wire logic i_s1n,
  input wire logic i_s2,
  input wire logic i_wen,
  input wire logic i_oen,
  input wire logic i_un,
  input wire logic i_ln,
  input wire logic [15:0] i_d,
  input wire logic i_doen,
  output logic [15:0] o_d
);
  bit [15:0] mem [int];
  logic [15:0] junk = 16'hA5C3;
  // Selected only with both selects right and a lane on
  wire sel = !i_s1n && i_s2 && !(i_un && i_ln);
  // Lanes stored while select, strobe, lane and host data drive overlap
  always @(posedge i_clk) begin
    junk <= junk + 16'h3B1D;
    if (sel && !i_wen && !i_doen) begin
      mem[i_a] = {i_un ? mem[i_a][15:8] : i_d[15:8], i_ln ? mem[i_a][7:0] : i_d[7:0]};
    end
  end
  // Floating bytes show a pattern that moves every cycle
  always @* begin
    o_d = junk;
    if (sel && i_wen && !i_oen) begin
      if (!i_ln) o_d[7:0] = mem[i_a][7:0];
      if (!i_un) o_d[15:8] = mem[i_a][15:8];
    end
  end
endmodule : asw_mem_model

// file: bench/asw_host_monitor.sv
// Pin protocol checker for the SRAM host controller
`timescale 1ns/1ns
module asw_host_monitor (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic [1:0] i_req_lanes,
  input wire logic o_rsp_valid,
  input wire logic o_retained,
  input wire logic o_select_first_n,
  input wire logic o_select_second,
  input wire logic o_write_en_n,
  input wire logic o_output_en_n,
  input wire logic o_upper_lane_en_n,
  input wire logic o_lower_lane_en_n,
  input wire logic o_sram_data_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire sel = !o_select_first_n && o_select_second;
  wire lane = !(o_upper_lane_en_n && o_lower_lane_en_n);
  sequence s_take;
    i_req_valid && o_req_ready && i_req_lanes != 2'h0;
  endsequence
  sequence s_float;
    o_sram_data_oe_n [*2];
  endsequence
  AST_SEL_PAIR: assert property (o_select_first_n == !o_select_second)
    else $error("selects disagree");
  AST_LANE_IDLE: assert property (!sel |-> !lane)
    else $error("lane enabled while deselected");
  AST_READ_WE: assert property (!o_output_en_n |-> o_write_en_n && sel)
    else $error("output enable without read setup");
  AST_NO_FIGHT: assert property (!o_sram_data_oe_n |-> o_output_en_n)
    else $error("host drives during output enable");
  AST_WR_START: assert property ($fell(o_write_en_n) |-> sel && lane)
    else $error("write strobe without select and lane");
  AST_FLOAT: assert property ($fell(o_write_en_n) |-> s_float)
    else $error("data driven too soon after strobe");
  AST_HOLD: assert property ($rose(o_write_en_n) |-> !o_sram_data_oe_n ##1 o_sram_data_oe_n)
    else $error("write data not held past strobe");
  AST_END: assert property ($rose(o_write_en_n) |-> !sel && o_output_en_n)
    else $error("select not released with strobe");
  AST_RSP: assert property (s_take |-> ##7 o_rsp_valid)
    else $error("response not after seven cycles");
  AST_RETAIN: assert property (o_retained |-> !sel && o_sram_data_oe_n)
    else $error("selected while retained");
endmodule : asw_host_monitor
bind asw_host asw_host_monitor u_mon (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_lanes(i_req_lanes),
  .o_rsp_valid(o_rsp_valid), .o_retained(o_retained), .o_select_first_n(o_select_first_n),
  .o_select_second(o_select_second), .o_write_en_n(o_write_en_n),
  .o_output_en_n(o_output_en_n), .o_upper_lane_en_n(o_upper_lane_en_n),
  .o_lower_lane_en_n(o_lower_lane_en_n), .o_sram_data_oe_n(o_sram_data_oe_n));

// file: bench/asw_host_tb.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ns
module asw_host_tb;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_req_valid = 1'b0, i_req_write = 1'b0;
  logic i_retain_req = 1'b0;
  logic [17:0] i_req_addr = 18'h0;
  logic [15:0] i_req_wdata = 16'h0;
  logic [1:0] i_req_lanes = 2'h0;
  logic o_req_ready, o_rsp_valid, o_retained, o_select_first_n, o_select_second;
  logic o_write_en_n, o_output_en_n, o_upper_lane_en_n, o_lower_lane_en_n, o_sram_data_oe_n;
  logic [15:0] o_rsp_rdata, i_sram_data, o_sram_data;
  logic [17:0] o_sram_addr;
  logic [31:0] seed = 32'h75BEE993;
  logic [31:0] r;
  int mismatches = 0, n_compared = 0, cyc = 0, k;
  bit [15:0] ref_m [int];
  asw_host u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_req_lanes(i_req_lanes), .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata), .i_retain_req(i_retain_req), .o_retained(o_retained),
    .o_sram_addr(o_sram_addr), .o_select_first_n(o_select_first_n),
    .o_select_second(o_select_second), .o_write_en_n(o_write_en_n),
    .o_output_en_n(o_output_en_n), .o_upper_lane_en_n(o_upper_lane_en_n),
    .o_lower_lane_en_n(o_lower_lane_en_n), .i_sram_data(i_sram_data),
    .o_sram_data(o_sram_data), .o_sram_data_oe_n(o_sram_data_oe_n));
  asw_mem_model u_mem (.i_clk(i_ref_clk), .i_a(o_sram_addr), .i_s1n(o_select_first_n),
    .i_s2(o_select_second), .i_wen(o_write_en_n), .i_oen(o_output_en_n),
    .i_un(o_upper_lane_en_n), .i_ln(o_lower_lane_en_n), .i_d(o_sram_data),
    .i_doen(o_sram_data_oe_n), .o_d(i_sram_data));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Four low words and four at the top of the array
  function automatic logic [17:0] addr(input logic [2:0] s);
    return s[2] ? {16'hFFFF, s[1:0]} : {16'h0, s[1:0]};
  endfunction : addr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Bounded count of cycles until the controller is ready again
  task automatic wait_ready();
    k = 0;
    while (!o_req_ready && k < 30) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
  endtask : wait_ready
  // One request; the reference memory merges only enabled bytes
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
                    input logic [1:0] l);
    logic [15:0] m;
    m = {{8{l[1]}}, {8{l[0]}}};
    wait_ready();
    {i_req_valid, i_req_write, i_req_addr, i_req_wdata, i_req_lanes} = {1'b1, w, a, d, l};
    @(posedge i_ref_clk);
    #1;
    i_req_valid = 1'b0;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end while (!o_rsp_valid && k < 20);
    // Read: 5 access cycles plus one; write: 2 float plus 4 pulse cycles
    chk(16'(k), 16'h6);
    if (w) ref_m[a] = l == 2'h3 ? d : (d & m) | (ref_m[a] & ~m);
    else chk(o_rsp_rdata & m, ref_m[a] & m);
  endtask : op
  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    for (int i = 0; i < 8; i++) op(1'b1, addr(3'(i)), rnd(), 2'h3);
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      op(r[3], addr(r[2:0]), r[31:16], r[5:4] == 2'h0 ? 2'h1 : r[5:4]);
    end
    // A request with no lane is never taken
    i_req_lanes = 2'h0;
    i_req_valid = 1'b1;
    k = 0;
    repeat (10) begin
      @(posedge i_ref_clk);
      #1;
      k += o_rsp_valid;
    end
    chk(16'(k), 16'h0);
    i_req_valid = 1'b0;
    i_retain_req = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk(16'({o_retained, o_req_ready, o_select_first_n}), 16'h5);
    i_retain_req = 1'b0;
    wait_ready();
    chk(16'(k >= 5), 16'h1);
    op(1'b0, addr(3'h7), 16'h0, 2'h3);
    results();
  end
endmodule : asw_host_tb
